// [include/rcc_pkg.sv]
// package for the reset cause controller: constants, modes and carrier structs
package rcc_pkg;
  localparam logic [7:0] FLASH_RESET_KEY  = 8'h55;
  localparam logic [4:0] WDOG_EN_CODE_A   = 5'h0A;
  localparam logic [4:0] WDOG_EN_CODE_B   = 5'h15;
  localparam logic [4:0] WDOG_EN_RESET    = 5'h0A;
  localparam logic [2:0] WDOG_SEL_RESET   = 3'h3;
  localparam logic [7:0] PORT_RESET       = 8'hFF;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;
  localparam int         CLK_MHZ          = 200;
  localparam int         SRESET_DELAY_NS  = 100;
  localparam int         SRESET_CYCLES    = (SRESET_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int         RESET_PULSE_CYC  = 4;
  localparam int         WDOG_W           = 19;
  localparam int         TB_W             = 16;

  typedef enum logic [1:0] {
    RCC_MODE_FAST,
    RCC_MODE_SLOW,
    RCC_MODE_IDLE,
    RCC_MODE_SLEEP
  } rcc_mode_t;

  typedef enum logic [2:0] {
    RCC_CAUSE_NONE,
    RCC_CAUSE_POWER_ON,
    RCC_CAUSE_LOW_VOLT,
    RCC_CAUSE_WDOG_RUN,
    RCC_CAUSE_WDOG_SLEEP,
    RCC_CAUSE_FLASH,
    RCC_CAUSE_WDOG_FIELD
  } rcc_cause_t;

  // core reset requests sent out to the rest of the device
  typedef struct packed {
    logic full_reset;
    logic pc_sp_reset;
    logic intr_disable;
    logic timers_off;
    logic ports_input;
  } rcc_core_rst_t;

  // reset-cause flags
  typedef struct packed {
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic low_voltage_reset_flag;
    logic wdog_register_reset_flag;
  } rcc_flags_t;
endpackage

// [rtl/rcc_delay.sv]
// one-shot delay: pulses done a fixed number of cycles after start
module rcc_delay #(
  parameter int CYCLES = 20
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  input  wire logic cancel,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cancel) begin
        busy      <= 1'b0;
        count_reg <= '0;
      end else if (start && !busy) begin
        busy      <= 1'b1;
        count_reg <= CW'(CYCLES - 1);
      end else if (busy) begin
        if (count_reg == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/rcc_top.sv]
// reset cause controller: reset generation, watchdog and reset-cause flags
module rcc_top #(
  parameter int SRESET_CYC = rcc_pkg::SRESET_CYCLES,
  parameter int PULSE_CYC  = rcc_pkg::RESET_PULSE_CYC
) (
  // clock and reset (rst_n is the power-on reset)
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // asynchronous sources
  input  wire logic                   low_voltage_reset,
  input  wire logic                   lirc_tick,
  // core status
  input  wire rcc_pkg::rcc_mode_t     op_mode,
  input  wire logic                   wdog_clear,
  // flash control write
  input  wire logic                   flash_ctl_second_wr,
  input  wire logic [7:0]             flash_ctl_second_reg,
  // watchdog control write
  input  wire logic                   wdog_ctl_wr,
  input  wire logic [4:0]             wdog_enable_field,
  input  wire logic [2:0]             wdog_period_sel,
  // flag writes from software: lvr and wrf writes, a power-down set, and one clear for timeout and power-down
  input  wire logic                   lvr_flag_wr,
  input  wire logic                   lvr_flag_wdata,
  input  wire logic                   wrf_flag_wr,
  input  wire logic                   wrf_flag_wdata,
  input  wire logic                   pdf_set,
  input  wire logic                   status_clr,
  // outputs
  output rcc_pkg::rcc_core_rst_t      core_rst,
  output rcc_pkg::rcc_flags_t         flags,
  output rcc_pkg::rcc_cause_t         last_cause,
  output logic [7:0]                  program_counter_low_byte,
  output logic [7:0]                  port_data,
  output logic [7:0]                  port_dir,
  output logic [4:0]                  wdog_enable_reg,
  output logic [2:0]                  wdog_sel_reg
);
  logic [1:0] lv_sync_reg;
  logic [1:0] tick_sync_reg;
  logic       tick_prev_reg;
  logic       lv_prev_reg;
  logic       por_pending_reg;
  logic [rcc_pkg::WDOG_W-1:0] wdog_cnt_reg;
  logic [rcc_pkg::TB_W-1:0]   tb_cnt_reg;
  logic [3:0] pulse_cnt_reg;
  logic       field_bad;
  logic       field_busy;
  logic       field_done;
  logic       tick_rise;
  logic       lv_event;
  logic       flash_event;
  logic       wdog_expire;
  logic       sleeping;
  logic       wdog_full;
  logic       wdog_part;
  logic       any_full;

  function automatic logic field_ok(input logic [4:0] f);
    return (f == rcc_pkg::WDOG_EN_CODE_A) || (f == rcc_pkg::WDOG_EN_CODE_B);
  endfunction

  function automatic logic [rcc_pkg::WDOG_W-1:0] wdog_limit(input logic [2:0] s);
    case (s)
      3'h0:    return rcc_pkg::WDOG_W'(1) << 8;
      3'h1:    return rcc_pkg::WDOG_W'(1) << 10;
      3'h2:    return rcc_pkg::WDOG_W'(1) << 12;
      3'h3:    return rcc_pkg::WDOG_W'(1) << 14;
      default: return rcc_pkg::WDOG_W'(1) << (5'(s) + 5'h0B);
    endcase
  endfunction

  // synchronisers for the pin-level inputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_sync_reg   <= 2'h0;
      tick_sync_reg <= 2'h0;
      tick_prev_reg <= 1'b0;
      lv_prev_reg   <= 1'b0;
    end else begin
      lv_sync_reg   <= {lv_sync_reg[0], low_voltage_reset};
      tick_sync_reg <= {tick_sync_reg[0], lirc_tick};
      tick_prev_reg <= tick_sync_reg[1];
      lv_prev_reg   <= lv_sync_reg[1];
    end
  end

  assign sleeping    = (op_mode == rcc_pkg::RCC_MODE_IDLE) || (op_mode == rcc_pkg::RCC_MODE_SLEEP);
  assign tick_rise   = tick_sync_reg[1] && !tick_prev_reg;
  // the low-voltage detector is off in sleep and idle
  assign lv_event    = lv_sync_reg[1] && !lv_prev_reg && !sleeping;
  assign flash_event = flash_ctl_second_wr && (flash_ctl_second_reg == rcc_pkg::FLASH_RESET_KEY);
  assign wdog_expire = tick_rise && field_ok(wdog_enable_reg) && (wdog_cnt_reg == wdog_limit(wdog_sel_reg) - 1'b1);
  // run-mode time-out is a full reset
  assign wdog_full   = wdog_expire && !sleeping;
  // sleep time-out is a partial reset
  assign wdog_part   = wdog_expire && sleeping;
  assign field_bad   = !field_ok(wdog_enable_reg);
  assign any_full    = flash_event || wdog_full || lv_event || field_done;

  // delayed reset after a bad enable field
  rcc_delay #(
    .CYCLES (SRESET_CYC)
  ) u_field_delay (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (field_bad),
    .cancel  (any_full),
    .busy    (field_busy),
    .done    (field_done)
  );

  // watchdog control register; a full reset restores its reset value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_enable_reg <= rcc_pkg::WDOG_EN_RESET;
      wdog_sel_reg    <= rcc_pkg::WDOG_SEL_RESET;
    end else if (any_full) begin
      wdog_enable_reg <= rcc_pkg::WDOG_EN_RESET;
      wdog_sel_reg    <= rcc_pkg::WDOG_SEL_RESET;
    end else if (wdog_ctl_wr) begin
      wdog_enable_reg <= wdog_enable_field;
      wdog_sel_reg    <= wdog_period_sel;
    end
  end

  // counters cleared on any reset, watchdog restarts at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_cnt_reg <= '0;
      tb_cnt_reg   <= '0;
    end else if (any_full || wdog_expire || wdog_clear || wdog_ctl_wr) begin
      wdog_cnt_reg <= '0;
      tb_cnt_reg   <= (any_full || wdog_expire) ? '0 : tb_cnt_reg;
    end else if (tick_rise) begin
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      tb_cnt_reg   <= tb_cnt_reg + 1'b1;
    end
  end

  // reset-cause flags, all cleared by power-on; one process so the struct has one driver
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      if (wdog_expire) begin
        // timeout set, power-down kept in run mode
        flags.watchdog_timeout_flag <= 1'b1;
        if (sleeping) begin
          flags.power_down_flag <= 1'b1;
        end
      end else if (status_clr) begin
        flags.watchdog_timeout_flag <= 1'b0;
        flags.power_down_flag       <= 1'b0;
      end else if (pdf_set) begin
        flags.power_down_flag <= 1'b1;
      end
      // low-voltage flag set; cleared only by a software zero, set wins
      if (lv_event) begin
        flags.low_voltage_reset_flag <= 1'b1;
      end else if (lvr_flag_wr && !lvr_flag_wdata) begin
        flags.low_voltage_reset_flag <= 1'b0;
      end
      // field reset flag, set wins over software clear
      if (field_done) begin
        flags.wdog_register_reset_flag <= 1'b1;
      end else if (wrf_flag_wr) begin
        flags.wdog_register_reset_flag <= wrf_flag_wdata;
      end
    end
  end

  // reset pulse stretcher and cause record
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_reg   <= 4'(PULSE_CYC);
      por_pending_reg <= 1'b1;
      last_cause      <= rcc_pkg::RCC_CAUSE_POWER_ON;
    end else begin
      if (any_full) begin
        pulse_cnt_reg <= 4'(PULSE_CYC);
      end else if (pulse_cnt_reg != 4'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
      if (pulse_cnt_reg == 4'h1) begin
        por_pending_reg <= 1'b0;
      end
      if (flash_event) begin
        last_cause <= rcc_pkg::RCC_CAUSE_FLASH;
      end else if (lv_event) begin
        last_cause <= rcc_pkg::RCC_CAUSE_LOW_VOLT;
      end else if (field_done) begin
        last_cause <= rcc_pkg::RCC_CAUSE_WDOG_FIELD;
      end else if (wdog_full) begin
        last_cause <= rcc_pkg::RCC_CAUSE_WDOG_RUN;
      end else if (wdog_part) begin
        last_cause <= rcc_pkg::RCC_CAUSE_WDOG_SLEEP;
      end
    end
  end

  // core reset requests
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rst <= '1;
    end else begin
      core_rst.full_reset   <= any_full || (pulse_cnt_reg > 4'h1);
      // only pc and stack pointer on sleep time-out
      // pc zero, stack top on full reset
      core_rst.pc_sp_reset  <= any_full || wdog_part || (pulse_cnt_reg > 4'h1);
      core_rst.intr_disable <= por_pending_reg && (pulse_cnt_reg > 4'h1);
      core_rst.timers_off   <= por_pending_reg && (pulse_cnt_reg > 4'h1);
      core_rst.ports_input  <= any_full || (pulse_cnt_reg > 4'h1);
    end
  end

  // ports to all-ones inputs; pc low byte cleared
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_data                <= rcc_pkg::PORT_RESET;
      port_dir                 <= rcc_pkg::PORT_RESET;
      program_counter_low_byte <= rcc_pkg::ZERO_BYTE;
    end else begin
      if (any_full) begin
        port_data <= rcc_pkg::PORT_RESET;
        port_dir  <= rcc_pkg::PORT_RESET;
      end
      if (any_full || wdog_part) begin
        program_counter_low_byte <= rcc_pkg::ZERO_BYTE;
      end
    end
  end

  // checks
  sequence sleep_expire_s;
    wdog_expire && sleeping;
  endsequence

  flash_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flash_event |=> core_rst.full_reset)
    else $error("flash key did not reset");
  run_timeout_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wdog_full |=> flags.watchdog_timeout_flag && core_rst.full_reset
      && (flags.power_down_flag == $past(flags.power_down_flag)))
    else $error("run time-out flags wrong");
  sleep_partial_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_expire_s and (!any_full && pulse_cnt_reg < 4'h2) |=> core_rst.pc_sp_reset && !core_rst.ports_input)
    else $error("sleep time-out reset wrong");
  sleep_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_expire_s |=> flags.watchdog_timeout_flag && flags.power_down_flag)
    else $error("sleep time-out flags wrong");
  lv_keeps_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lv_event && !wdog_expire && !status_clr && !pdf_set |=> $stable(flags.watchdog_timeout_flag)
      && $stable(flags.power_down_flag))
    else $error("low-voltage changed flags");
  lv_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lv_event |=> flags.low_voltage_reset_flag && core_rst.full_reset)
    else $error("low-voltage flag not set");
  lv_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flags.low_voltage_reset_flag && !(lvr_flag_wr && !lvr_flag_wdata) |=> flags.low_voltage_reset_flag)
    else $error("low-voltage flag lost");
  field_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    field_done |=> flags.wdog_register_reset_flag && core_rst.full_reset)
    else $error("field reset missing");
  wdog_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    any_full |=> wdog_cnt_reg == '0 && tb_cnt_reg == '0)
    else $error("counters not cleared");
  ports_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wdog_full |=> port_dir == rcc_pkg::PORT_RESET && port_data == rcc_pkg::PORT_RESET)
    else $error("ports not inputs");
endmodule

// [verif/testbench.sv]
// self-checking bench for the reset cause controller, with a flag model in integers
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SRST  = 3;
  localparam int PULSE = 4;

  logic                   sys_clk;
  logic                   rst_n;
  logic                   low_voltage_reset;
  logic                   lirc_tick;
  rcc_pkg::rcc_mode_t     op_mode;
  logic                   wdog_clear;
  logic                   flash_ctl_second_wr;
  logic [7:0]             flash_ctl_second_reg;
  logic                   wdog_ctl_wr;
  logic [4:0]             wdog_enable_field;
  logic [2:0]             wdog_period_sel;
  logic                   lvr_flag_wr;
  logic                   lvr_flag_wdata;
  logic                   wrf_flag_wr;
  logic                   wrf_flag_wdata;
  logic                   pdf_set;
  logic                   status_clr;
  rcc_pkg::rcc_core_rst_t core_rst;
  rcc_pkg::rcc_flags_t    flags;
  rcc_pkg::rcc_cause_t    last_cause;
  logic [7:0]             program_counter_low_byte;
  logic [7:0]             port_data;
  logic [7:0]             port_dir;
  logic [4:0]             wdog_enable_reg;
  logic [2:0]             wdog_sel_reg;
  logic                   seen_full;
  logic                   seen_pcsp;
  int                     bad_count;
  int                     checks;
  int                     exp_to;
  int                     exp_pdf;
  int                     exp_low_voltage_reset_flag;
  logic [7:0]             rnd;

  rcc_top #(.SRESET_CYC(SRST), .PULSE_CYC(PULSE)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .low_voltage_reset(low_voltage_reset), .lirc_tick(lirc_tick),
    .op_mode(op_mode), .wdog_clear(wdog_clear), .flash_ctl_second_wr(flash_ctl_second_wr),
    .flash_ctl_second_reg(flash_ctl_second_reg), .wdog_ctl_wr(wdog_ctl_wr),
    .wdog_enable_field(wdog_enable_field), .wdog_period_sel(wdog_period_sel), .lvr_flag_wr(lvr_flag_wr),
    .lvr_flag_wdata(lvr_flag_wdata), .wrf_flag_wr(wrf_flag_wr), .wrf_flag_wdata(wrf_flag_wdata),
    .pdf_set(pdf_set), .status_clr(status_clr), .core_rst(core_rst), .flags(flags), .last_cause(last_cause),
    .program_counter_low_byte(program_counter_low_byte), .port_data(port_data), .port_dir(port_dir),
    .wdog_enable_reg(wdog_enable_reg), .wdog_sel_reg(wdog_sel_reg));

  always #2.5 sys_clk = ~sys_clk;

  // latches any full or pc/sp reset request seen since the last clear
  always @(posedge sys_clk) begin
    if (core_rst.full_reset === 1'b1) seen_full = 1'b1;
    if (core_rst.pc_sp_reset === 1'b1) seen_pcsp = 1'b1;
  end

  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_flags;
    chk("timeout_flag", 8'(exp_to), 8'(flags.watchdog_timeout_flag));
    chk("power_down_flag", 8'(exp_pdf), 8'(flags.power_down_flag));
    chk("low_voltage_flag", 8'(exp_low_voltage_reset_flag), 8'(flags.low_voltage_reset_flag));
  endtask

  // slow-oscillator edges, each level held long enough for the synchroniser
  task automatic tick_n(input int n);
    repeat (n) begin
      lirc_tick = 1'b1;
      cyc(3);
      lirc_tick = 1'b0;
      cyc(3);
    end
  endtask

  task automatic clean;
    status_clr = 1'b1;
    lvr_flag_wr = 1'b1;
    lvr_flag_wdata = 1'b0;
    wrf_flag_wr = 1'b1;
    wrf_flag_wdata = 1'b0;
    cyc(1);
    {status_clr, lvr_flag_wr, wrf_flag_wr} = 3'h0;
    cyc(1);
    exp_to = 0;
    exp_pdf = 0;
    exp_low_voltage_reset_flag = 0;
    {seen_full, seen_pcsp} = 2'h0;
  endtask

  task automatic wdog_write(input logic [4:0] en, input logic [2:0] sel);
    wdog_ctl_wr = 1'b1;
    wdog_enable_field = en;
    wdog_period_sel = sel;
    cyc(1);
    wdog_ctl_wr = 1'b0;
  endtask

  task automatic lvr_pulse;
    low_voltage_reset = 1'b1;
    cyc(6);
    low_voltage_reset = 1'b0;
    cyc(PULSE + 6);
  endtask

  initial begin
    #100us;
    bad_count++;
    final_report();
  end

  initial begin
    void'($urandom(63293));
    {sys_clk, rst_n, low_voltage_reset, lirc_tick, wdog_clear, flash_ctl_second_wr} = 6'h00;
    {wdog_ctl_wr, lvr_flag_wr, lvr_flag_wdata, wrf_flag_wr, wrf_flag_wdata, pdf_set, status_clr} = 7'h00;
    op_mode = rcc_pkg::RCC_MODE_FAST;
    flash_ctl_second_reg = 8'h00;
    wdog_enable_field = 5'h0A;
    wdog_period_sel = 3'h3;
    {exp_to, exp_pdf, exp_low_voltage_reset_flag, bad_count, checks} = '0;
    {seen_full, seen_pcsp} = 2'h0;
    cyc(3);
    chk("intr_disable", 8'h01, 8'(core_rst.intr_disable));
    chk("timers_off", 8'h01, 8'(core_rst.timers_off));
    chk("port_data", rcc_pkg::PORT_RESET, port_data);
    chk("port_dir", rcc_pkg::PORT_RESET, port_dir);
    chk("pc_low", rcc_pkg::ZERO_BYTE, program_counter_low_byte);
    chk_flags();
    chk("wrf", 8'h00, 8'(flags.wdog_register_reset_flag));
    cyc(3);
    rst_n = 1'b1;
    cyc(PULSE + 4);
    chk("core_rst_idle", 8'h00, 8'(core_rst));
    // forget the power-on pulse before looking for new resets
    {seen_full, seen_pcsp} = 2'h0;
    // a wrong key must not reset, the key itself resets on the next edge
    rnd = 8'($urandom % 256);
    if (rnd == rcc_pkg::FLASH_RESET_KEY) rnd = 8'h54;
    flash_ctl_second_reg = rnd;
    flash_ctl_second_wr = 1'b1;
    cyc(1);
    flash_ctl_second_wr = 1'b0;
    cyc(4);
    chk("seen_full_badkey", 8'h00, 8'(seen_full));
    flash_ctl_second_reg = rcc_pkg::FLASH_RESET_KEY;
    flash_ctl_second_wr = 1'b1;
    cyc(1);
    flash_ctl_second_wr = 1'b0;
    chk("full_reset_key", 8'h01, 8'(core_rst.full_reset));
    chk("cause_flash", 8'(rcc_pkg::RCC_CAUSE_FLASH), 8'(last_cause));
    chk("ports_input_key", 8'h01, 8'(core_rst.ports_input));
    chk("pc_sp_key", 8'h01, 8'(core_rst.pc_sp_reset));
    chk("intr_key", 8'h00, 8'(core_rst.intr_disable));
    cyc(PULSE + 4);
    chk("full_reset_end", 8'h00, 8'(core_rst.full_reset));
    // run-mode time-out, with a clear part way that restarts the count
    clean();
    pdf_set = 1'b1;
    cyc(1);
    pdf_set = 1'b0;
    exp_pdf = 1;
    wdog_write(rcc_pkg::WDOG_EN_CODE_A, 3'h0);
    tick_n(200);
    wdog_clear = 1'b1;
    cyc(1);
    wdog_clear = 1'b0;
    tick_n(200);
    chk("seen_full_cleared", 8'h00, 8'(seen_full));
    tick_n(70);
    cyc(PULSE + 4);
    chk("seen_full_wdog", 8'h01, 8'(seen_full));
    exp_to = 1;
    chk_flags();
    chk("cause_wdog_run", 8'(rcc_pkg::RCC_CAUSE_WDOG_RUN), 8'(last_cause));
    chk("port_dir_wdog", rcc_pkg::PORT_RESET, port_dir);
    // low voltage in run mode keeps timeout and power-down as they were
    seen_full = 1'b0;
    lvr_pulse();
    chk("seen_full_lvr", 8'h01, 8'(seen_full));
    exp_low_voltage_reset_flag = 1;
    chk_flags();
    chk("cause_lvr", 8'(rcc_pkg::RCC_CAUSE_LOW_VOLT), 8'(last_cause));
    lvr_flag_wr = 1'b1;
    lvr_flag_wdata = 1'b1;
    cyc(1);
    chk_flags();
    lvr_flag_wdata = 1'b0;
    cyc(1);
    lvr_flag_wr = 1'b0;
    exp_low_voltage_reset_flag = 0;
    cyc(1);
    chk_flags();
    // low voltage is ignored while asleep
    clean();
    op_mode = rcc_pkg::RCC_MODE_IDLE;
    lvr_pulse();
    chk("seen_full_sleep_lvr", 8'h00, 8'(seen_full));
    chk_flags();
    // sleep time-out clears only program counter and stack pointer
    op_mode = rcc_pkg::RCC_MODE_SLEEP;
    wdog_write(rcc_pkg::WDOG_EN_CODE_B, 3'h0);
    tick_n(270);
    cyc(PULSE + 4);
    chk("seen_pcsp_sleep", 8'h01, 8'(seen_pcsp));
    chk("seen_full_sleep", 8'h00, 8'(seen_full));
    chk("sel_kept", 8'h00, 8'(wdog_sel_reg));
    exp_to = 1;
    exp_pdf = 1;
    chk_flags();
    chk("cause_wdog_sleep", 8'(rcc_pkg::RCC_CAUSE_WDOG_SLEEP), 8'(last_cause));
    // a corrupt enable field resets only after the fixed delay
    op_mode = rcc_pkg::RCC_MODE_SLOW;
    clean();
    rnd = 8'($urandom % 32);
    if (rnd[4:0] == rcc_pkg::WDOG_EN_CODE_A || rnd[4:0] == rcc_pkg::WDOG_EN_CODE_B) rnd = 8'h1F;
    wdog_write(rnd[4:0], 3'($urandom % 8));
    cyc(SRST);
    chk("seen_full_early", 8'h00, 8'(seen_full));
    cyc(PULSE + 4);
    chk("seen_full_field", 8'h01, 8'(seen_full));
    chk("wrf", 8'h01, 8'(flags.wdog_register_reset_flag));
    chk("cause_field", 8'(rcc_pkg::RCC_CAUSE_WDOG_FIELD), 8'(last_cause));
    chk("enable_restored", 8'(rcc_pkg::WDOG_EN_RESET), 8'(wdog_enable_reg));
    // one bad field gives exactly one reset
    seen_full = 1'b0;
    cyc(SRST + PULSE + 4);
    chk("seen_full_again", 8'h00, 8'(seen_full));
    final_report();
  end
endmodule
